// File: include/lookup_cfg_pkg.sv
// Purpose: Constants and carrier types for the lookup configuration bank
// Assumes: APB byte address is four times the register index
// Notes: Indices 0x300, 0x313 and 0x314 hold control bits kept outside the main slice
package lookup_cfg_pkg;
    // ----------------------------------------------------------------
    // Bus and register indices
    // ----------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam logic [9:0] IDX_SWITCH_OP = 10'h300;
    localparam logic [9:0] IDX_ADDR_BYTE3 = 10'h305;
    localparam logic [9:0] IDX_ADDR_BYTE4 = 10'h306;
    localparam logic [9:0] IDX_ADDR_BYTE5 = 10'h307;
    localparam logic [9:0] IDX_MAX_PAYLOAD = 10'h308;
    localparam logic [9:0] IDX_TAG_TYPE = 10'h30A;
    localparam logic [9:0] IDX_SHAPER_ACCT = 10'h30E;
    localparam logic [9:0] IDX_LOOKUP0 = 10'h310;
    localparam logic [9:0] IDX_AGE_PERIOD = 10'h313;
    localparam logic [9:0] IDX_UNKNOWN_VLAN = 10'h314;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int DOUBLE_TAG_BIT = 7;
    localparam int SOFT_RESET_BIT = 1;
    localparam int SHAPE_ACCT_BIT = 1;
    localparam int POLICE_ACCT_BIT = 0;
    localparam int VLAN_EN_BIT = 7;
    localparam int BAD_VLAN_BIT = 6;
    localparam int AGE_CNT_LSB = 3;
    localparam int RSVD_MC_BIT = 2;
    localparam int HASH_LSB = 0;
    localparam int UNKNOWN_FWD_BIT = 0;
    // ----------------------------------------------------------------
    // Reset values and limits
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_BYTE_RST = 8'hFF;
    localparam logic [15:0] MAX_PAYLOAD_RST = 16'h07D0;
    localparam logic [15:0] JUMBO_PAYLOAD = 16'h2328;
    localparam logic [15:0] TAG_TYPE_RST = 16'h9100;
    localparam logic [1:0] SHAPER_ACCT_RST = 2'h3;
    localparam logic [7:0] LOOKUP0_RST = 8'h61;
    localparam logic [7:0] SWITCH_OP_RST = 8'h00;
    localparam logic [7:0] AGE_PERIOD_RST = 8'h01;
    localparam logic [7:0] UNKNOWN_VLAN_RST = 8'h00;
    localparam logic [15:0] GAP_PREAMBLE_BYTES = 16'h0014;
    localparam logic [9:0] CRC_POLY = 10'h233;
    // ----------------------------------------------------------------
    // Hash selection codes
    // ----------------------------------------------------------------
    localparam logic [1:0] HASH_DIRECT_LO = 2'h0;
    localparam logic [1:0] HASH_CRC = 2'h1;
    localparam logic [1:0] HASH_XOR = 2'h2;
    localparam logic [1:0] HASH_DIRECT_HI = 2'h3;
    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [47:0] station_addr;
        logic [13:0] max_payload_length;
        logic [15:0] tag_type_value;
        logic shape_full;
        logic police_full;
        logic vlan_en;
        logic bad_vlan_discard;
        logic [2:0] age_count;
        logic rsvd_mc_en;
        logic [1:0] table_hash_select;
        logic provider_outer_tag;
        logic unknown_fwd;
        logic [7:0] age_period;
    } cfg_t;
    typedef struct packed {
        logic sof;
        logic data_valid;
        logic [15:0] frame_len;
        logic vid_check;
        logic vid_invalid;
        logic vid_unknown;
        logic sa_check;
        logic [47:0] src_addr;
        logic [47:0] dst_addr;
        logic entry_update;
    } frame_in_t;
    typedef struct packed {
        logic truncate;
        logic drop;
        logic to_host;
        logic self_match;
        logic rsvd_mc_lookup;
        logic vlan_active;
        logic provider_outer_tag;
        logic [15:0] tag_type_value;
        logic [47:0] pause_src;
        logic [2:0] age_field;
        logic [10:0] aging_time;
    } frame_out_t;
endpackage

// File: core/credit_debit.sv
// Purpose: Credit deduction for one shaper or policer
// Assumes: Length valid is a one-cycle pulse
// Notes: Result held until the next pulse
`timescale 1ns/100ps
`default_nettype none
module credit_debit
    import lookup_cfg_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Frame
    input wire logic len_valid,
    input wire logic [15:0] frame_len,
    input wire logic acct_full,
    // Result
    output logic [15:0] debit_q
);
    logic [15:0] debit_d;

    always_comb begin
        debit_d = debit_q;
        if (len_valid) begin
            debit_d = acct_full ? 16'(frame_len + GAP_PREAMBLE_BYTES) : frame_len;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debit_q <= 16'h0000;
        end else begin
            debit_q <= debit_d;
        end
    end

    debit_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        len_valid |=> debit_q == ($past(acct_full) ? 16'($past(frame_len) + GAP_PREAMBLE_BYTES)
                                                    : $past(frame_len)))
        else $error("credit debit wrong for accounting mode");
endmodule // credit_debit
`default_nettype wire

// File: core/table_index_hash.sv
// Purpose: Dynamic lookup table index from destination address
// Assumes: Request is a one-cycle pulse
// Notes: Index held until the next request
`timescale 1ns/100ps
`default_nettype none
module table_index_hash
    import lookup_cfg_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request
    input wire logic req,
    input wire logic [47:0] dst_addr,
    input wire logic [1:0] table_hash_select,
    // Result
    output logic [9:0] index_q
);
    logic [9:0] index_d;
    logic [9:0] crc;

    always_comb begin
        crc = 10'h3FF;
        for (int i = 47; i >= 0; i--) begin
            crc = (crc[9] ^ dst_addr[i]) ? ({crc[8:0], 1'b0} ^ CRC_POLY) : {crc[8:0], 1'b0};
        end
        index_d = index_q;
        if (req) begin
            case (table_hash_select)
                HASH_CRC: index_d = crc;
                HASH_XOR: index_d = dst_addr[9:0] ^ dst_addr[19:10] ^ dst_addr[29:20]
                                    ^ dst_addr[39:30] ^ {2'h0, dst_addr[47:40]};
                default: index_d = dst_addr[9:0];
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_q <= 10'h000;
        end else begin
            index_q <= index_d;
        end
    end

    direct_index_a: assert property (@(posedge pclk) disable iff (!presetn)
        req && (table_hash_select == HASH_DIRECT_LO || table_hash_select == HASH_DIRECT_HI)
        |=> index_q == $past(dst_addr[9:0]))
        else $error("direct index is not the low address bits");
endmodule // table_index_hash
`default_nettype wire

// File: core/lookup_cfg_bank.sv
// Purpose: Global lookup configuration bank with APB slave and frame decisions
// Assumes: Frame inputs synchronous to pclk; upper station address bytes come from outside
// Notes: Zero wait states; settings are captured per frame at start of frame, except pause source, which follows the live station address
//
// Function
// - Three writable station address bytes for bits 23:0, each reset to FF.
// - Full 48-bit station address feeds pause source and self-address compare.
// - 14-bit payload limit, reset 2000; longer frames are truncated.
// - Payload limit accepts values up to 9000 for jumbo frames.
// - 16-bit tag type, reset 9100, for untagged and outer provider tags.
// - Outer provider tag handling only while double-tag enable is set.
// - Shaper accounting bit set adds gap and preamble to deducted credit.
// - Policer accounting bit set adds gap and preamble to deducted credit.
// - Lookup control 0 bit 7, reset 0, enables VLAN forwarding and filtering.
// - Bit 6 set drops invalid VLAN frames, clear sends them to host.
// - Enabled unknown-VLAN forwarding overrides the invalid VLAN choice.
// - Age count setting, reset 100, written into updated dynamic entries.
// - Aging time derives from age count together with age period.
// - Bit 2, reset 0, enables reserved multicast table lookups.
// - Hash select 00 or 11 indexes table with low 10 address bits.
// - Hash select 01 uses CRC hash, 10 uses XOR hash.
// - Self-clearing soft reset bit restores all register defaults.
`timescale 1ns/100ps
`default_nettype none
module lookup_cfg_bank
    import lookup_cfg_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Upper station address bytes
    input wire logic [23:0] station_addr_hi,
    // Frame side
    input wire frame_in_t frame_in,
    output frame_out_t frame_out,
    output logic [9:0] lookup_index,
    output logic [15:0] shaper_debit,
    output logic [15:0] policer_debit
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] byte3_q, byte3_d, byte4_q, byte4_d, byte5_q, byte5_d;
    logic [15:0] payload_q, payload_d, tag_q, tag_d;
    logic [1:0] acct_q, acct_d;
    logic [7:0] lk0_q, lk0_d, op_q, op_d, period_q, period_d, unk_q, unk_d;
    logic [31:0] rdata_q, rdata_d;
    logic [9:0] idx;
    logic setup, access, wr, hit, soft_rst;
    logic [31:0] rmux;
    cfg_t cfg, snap_q, snap_d, live;
    frame_out_t out_q, out_d;
    logic [13:0] cnt_q, cnt_d, cnt_base;

    assign idx = paddr[11:2];
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite && !pslverr;
    assign soft_rst = wr && idx == IDX_SWITCH_OP && pstrb[0] && pwdata[SOFT_RESET_BIT];

    // ----------------------------------------------------------------
    // Address decode and read mux
    // ----------------------------------------------------------------
    always_comb begin
        hit = 1'b1;
        rmux = 32'h0000_0000;
        case (idx)
            IDX_SWITCH_OP: rmux = {24'h0, op_q};
            IDX_ADDR_BYTE3: rmux = {24'h0, byte3_q};
            IDX_ADDR_BYTE4: rmux = {24'h0, byte4_q};
            IDX_ADDR_BYTE5: rmux = {24'h0, byte5_q};
            IDX_MAX_PAYLOAD: rmux = {16'h0, payload_q};
            IDX_TAG_TYPE: rmux = {16'h0, tag_q};
            IDX_SHAPER_ACCT: rmux = {30'h0, acct_q};
            IDX_LOOKUP0: rmux = {24'h0, lk0_q};
            IDX_AGE_PERIOD: rmux = {24'h0, period_q};
            IDX_UNKNOWN_VLAN: rmux = {24'h0, unk_q};
            default: hit = 1'b0;
        endcase
        if (paddr[13:12] != 2'h0) begin
            hit = 1'b0;
            rmux = 32'h0000_0000;
        end
    end

    assign pready = access;
    assign pslverr = access && !hit;
    assign prdata = rdata_q;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = setup ? rmux : rdata_q;
        byte3_d = byte3_q;
        byte4_d = byte4_q;
        byte5_d = byte5_q;
        payload_d = payload_q;
        tag_d = tag_q;
        acct_d = acct_q;
        lk0_d = lk0_q;
        op_d = op_q;
        period_d = period_q;
        unk_d = unk_q;
        if (soft_rst) begin
            byte3_d = ADDR_BYTE_RST;
            byte4_d = ADDR_BYTE_RST;
            byte5_d = ADDR_BYTE_RST;
            payload_d = MAX_PAYLOAD_RST;
            tag_d = TAG_TYPE_RST;
            acct_d = SHAPER_ACCT_RST;
            lk0_d = LOOKUP0_RST;
            op_d = SWITCH_OP_RST;
            period_d = AGE_PERIOD_RST;
            unk_d = UNKNOWN_VLAN_RST;
        end else if (wr) begin
            case (idx)
                IDX_SWITCH_OP: if (pstrb[0]) op_d = {pwdata[DOUBLE_TAG_BIT], 7'h00};
                IDX_ADDR_BYTE3: if (pstrb[0]) byte3_d = pwdata[7:0];
                IDX_ADDR_BYTE4: if (pstrb[0]) byte4_d = pwdata[7:0];
                IDX_ADDR_BYTE5: if (pstrb[0]) byte5_d = pwdata[7:0];
                IDX_MAX_PAYLOAD: begin
                    if (pstrb[0]) payload_d[7:0] = pwdata[7:0];
                    if (pstrb[1]) payload_d[15:8] = pwdata[15:8];
                end
                IDX_TAG_TYPE: begin
                    if (pstrb[0]) tag_d[7:0] = pwdata[7:0];
                    if (pstrb[1]) tag_d[15:8] = pwdata[15:8];
                end
                IDX_SHAPER_ACCT: if (pstrb[0]) acct_d = pwdata[1:0];
                IDX_LOOKUP0: if (pstrb[0]) lk0_d = pwdata[7:0];
                IDX_AGE_PERIOD: if (pstrb[0]) period_d = pwdata[7:0];
                IDX_UNKNOWN_VLAN: if (pstrb[0]) unk_d = {7'h00, pwdata[UNKNOWN_FWD_BIT]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            byte3_q <= ADDR_BYTE_RST;
            byte4_q <= ADDR_BYTE_RST;
            byte5_q <= ADDR_BYTE_RST;
            payload_q <= MAX_PAYLOAD_RST;
            tag_q <= TAG_TYPE_RST;
            acct_q <= SHAPER_ACCT_RST;
            lk0_q <= LOOKUP0_RST;
            op_q <= SWITCH_OP_RST;
            period_q <= AGE_PERIOD_RST;
            unk_q <= UNKNOWN_VLAN_RST;
        end else begin
            rdata_q <= rdata_d;
            byte3_q <= byte3_d;
            byte4_q <= byte4_d;
            byte5_q <= byte5_d;
            payload_q <= payload_d;
            tag_q <= tag_d;
            acct_q <= acct_d;
            lk0_q <= lk0_d;
            op_q <= op_d;
            period_q <= period_d;
            unk_q <= unk_d;
        end
    end

    // ----------------------------------------------------------------
    // Live settings
    // ----------------------------------------------------------------
    always_comb begin
        cfg.station_addr = {station_addr_hi, byte3_q, byte4_q, byte5_q};
        cfg.max_payload_length = payload_q[13:0];
        cfg.tag_type_value = tag_q;
        cfg.shape_full = acct_q[SHAPE_ACCT_BIT];
        cfg.police_full = acct_q[POLICE_ACCT_BIT];
        cfg.vlan_en = lk0_q[VLAN_EN_BIT];
        cfg.bad_vlan_discard = lk0_q[BAD_VLAN_BIT];
        cfg.age_count = lk0_q[AGE_CNT_LSB+:3];
        cfg.rsvd_mc_en = lk0_q[RSVD_MC_BIT];
        cfg.table_hash_select = lk0_q[HASH_LSB+:2];
        cfg.provider_outer_tag = op_q[DOUBLE_TAG_BIT];
        cfg.unknown_fwd = unk_q[UNKNOWN_FWD_BIT];
        cfg.age_period = period_q;
    end

    // ----------------------------------------------------------------
    // Per-frame decisions
    // ----------------------------------------------------------------
    always_comb begin
        snap_d = frame_in.sof ? cfg : snap_q;
        live = snap_d;
        cnt_base = frame_in.sof ? 14'h0000 : cnt_q;
        cnt_d = cnt_base;
        if (frame_in.data_valid && cnt_base != 14'h3FFF) begin
            cnt_d = 14'(cnt_base + 14'h0001);
        end
        out_d = out_q;
        out_d.truncate = frame_in.data_valid && cnt_base >= live.max_payload_length;
        out_d.pause_src = cfg.station_addr;
        out_d.tag_type_value = live.tag_type_value;
        out_d.provider_outer_tag = live.provider_outer_tag;
        out_d.vlan_active = live.vlan_en;
        out_d.rsvd_mc_lookup = live.rsvd_mc_en;
        out_d.aging_time = 11'(live.age_count * live.age_period);
        if (frame_in.sa_check) begin
            out_d.self_match = frame_in.src_addr == live.station_addr;
        end
        if (frame_in.entry_update) begin
            out_d.age_field = live.age_count;
        end
        if (frame_in.vid_check) begin
            out_d.drop = 1'b0;
            out_d.to_host = 1'b0;
            if (!live.vlan_en) begin
                out_d.drop = 1'b0;
            end else if (live.unknown_fwd && frame_in.vid_unknown) begin
                out_d.drop = 1'b0;
            end else if (frame_in.vid_invalid) begin
                out_d.drop = live.bad_vlan_discard;
                out_d.to_host = !live.bad_vlan_discard;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snap_q <= '0;
            cnt_q <= 14'h0000;
            out_q <= '0;
        end else begin
            snap_q <= snap_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign frame_out = out_q;

    // ----------------------------------------------------------------
    // Index and credit units
    // ----------------------------------------------------------------
    table_index_hash u_hash (
        .pclk(pclk),
        .presetn(presetn),
        .req(frame_in.sof),
        .dst_addr(frame_in.dst_addr),
        .table_hash_select(cfg.table_hash_select),
        .index_q(lookup_index)
    );

    credit_debit u_shaper (
        .pclk(pclk),
        .presetn(presetn),
        .len_valid(frame_in.sof),
        .frame_len(frame_in.frame_len),
        .acct_full(cfg.shape_full),
        .debit_q(shaper_debit)
    );

    credit_debit u_policer (
        .pclk(pclk),
        .presetn(presetn),
        .len_valid(frame_in.sof),
        .frame_len(frame_in.frame_len),
        .acct_full(cfg.police_full),
        .debit_q(policer_debit)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence soft_reset_write;
        soft_rst;
    endsequence

    sequence defaults_seen;
        byte3_q == ADDR_BYTE_RST && lk0_q == LOOKUP0_RST && op_q == SWITCH_OP_RST;
    endsequence

    soft_reset_clear_a: assert property (soft_reset_write |=> defaults_seen)
        else $error("soft reset did not restore defaults");
    station_low_write_a: assert property (wr && idx == IDX_ADDR_BYTE5 && pstrb[0]
        |=> byte5_q == $past(pwdata[7:0]) ##1 frame_out.pause_src[7:0] == byte5_q)
        else $error("station byte write not seen");
    payload_cut_a: assert property (frame_in.data_valid && !frame_in.sof
        && cnt_q >= snap_q.max_payload_length |=> frame_out.truncate)
        else $error("over-long payload not truncated");
    jumbo_store_a: assert property (wr && idx == IDX_MAX_PAYLOAD && pstrb[1:0] == 2'h3
        && pwdata[15:0] == JUMBO_PAYLOAD |=> payload_q == JUMBO_PAYLOAD)
        else $error("jumbo payload limit not accepted");
    tag_type_out_a: assert property (frame_in.sof
        |=> frame_out.tag_type_value == $past(tag_q))
        else $error("tag type not taken at frame start");
    outer_tag_off_a: assert property (frame_in.sof && !op_q[DOUBLE_TAG_BIT]
        |=> !frame_out.provider_outer_tag)
        else $error("outer tag active while disabled");
    bad_vlan_act_a: assert property (frame_in.vid_check && live.vlan_en &&
        frame_in.vid_invalid && !(live.unknown_fwd && frame_in.vid_unknown)
        |=> frame_out.drop == $past(live.bad_vlan_discard) && frame_out.to_host != frame_out.drop)
        else $error("invalid vlan handling wrong");
    unknown_override_a: assert property (frame_in.vid_check && live.unknown_fwd
        && frame_in.vid_unknown |=> !frame_out.drop && !frame_out.to_host)
        else $error("unknown vlan forwarding not taking precedence");
    age_field_a: assert property (frame_in.entry_update
        |=> frame_out.age_field == $past(live.age_count))
        else $error("age count not written to entry");
    frame_snapshot_a: assert property (!frame_in.sof ##1 !frame_in.sof
        |-> $stable(snap_q))
        else $error("settings changed inside a frame");
endmodule // lookup_cfg_bank
`default_nettype wire

// File: sim/lookup_cfg_bank_tb.sv
// Purpose: Self-checking bench for the lookup configuration bank
// Assumes: Zero-wait APB slave; frame results one cycle after start of frame
// Notes: Expected reads and frame results queued by drivers, checked by a monitor
`timescale 1ns/100ps
`default_nettype none
module lookup_cfg_bank_tb
    import lookup_cfg_pkg::*;
();
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sof_prev, ufwd;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, lfsr, r;
    logic [3:0] pstrb;
    logic [23:0] station_addr_hi;
    frame_in_t frame_in;
    frame_out_t frame_out;
    logic [9:0] lookup_index;
    logic [15:0] shaper_debit, policer_debit;
    logic [7:0] lk0;
    logic [1:0] acct;
    logic [32:0] rq[$];
    logic [126:0] fq[$];
    logic [32:0] rexp;
    logic [126:0] fexp;
    logic [126:0] fseen;
    int error_cnt, checks_done;
    logic [9:0] ri [10] = '{10'h305, 10'h306, 10'h307, 10'h308, 10'h30A, 10'h30E, 10'h310,
                            10'h313, 10'h314, 10'h300};
    logic [15:0] rv [10] = '{16'hFF, 16'hFF, 16'hFF, 16'h07D0, 16'h9100, 16'h3, 16'h61,
                             16'h1, 16'h0, 16'h0};
    logic [15:0] rm [7] = '{16'hFF, 16'hFF, 16'hFF, 16'hFFFF, 16'hFFFF, 16'h3, 16'hFF};

    lookup_cfg_bank i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .station_addr_hi(station_addr_hi),
        .frame_in(frame_in), .frame_out(frame_out), .lookup_index(lookup_index),
        .shaper_debit(shaper_debit), .policer_debit(policer_debit));

    assign fseen = {lookup_index, shaper_debit, policer_debit, frame_out.drop,
                    frame_out.to_host, frame_out.truncate, frame_out.self_match,
                    frame_out.vlan_active, frame_out.rsvd_mc_lookup,
                    frame_out.provider_outer_tag, frame_out.age_field, frame_out.aging_time,
                    frame_out.tag_type_value, frame_out.pause_src};

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    function automatic logic [9:0] crc10(input logic [47:0] a);
        logic [9:0] c;
        c = 10'h3FF;
        for (int k = 47; k >= 0; k--) begin
            if (c[9] ^ a[k])
                c = {c[8:0], 1'b0} ^ CRC_POLY;
            else
                c = {c[8:0], 1'b0};
        end
        return c;
    endfunction

    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d,
                       input logic [3:0] s, input logic [32:0] e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= {2'b00, idx, 2'b00};
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        if (!w)
            rq.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic frm(input logic [47:0] dst, input logic [15:0] len, input logic inv,
                       input logic unk);
        logic [9:0] ix;
        logic pass_vid;
        case (lk0[1:0])
            2'h1: ix = crc10(dst);
            2'h2: ix = dst[9:0] ^ dst[19:10] ^ dst[29:20] ^ dst[39:30] ^ {2'h0, dst[47:40]};
            default: ix = dst[9:0];
        endcase
        pass_vid = !lk0[7] || (ufwd && unk) || !inv;
        fq.push_back({ix, len + (acct[1] ? 16'h14 : 16'h0), len + (acct[0] ? 16'h14 : 16'h0),
                      !pass_vid && lk0[6], !pass_vid && !lk0[6], !lk0[0], lk0[0], lk0[7],
                      lk0[2], ufwd, lk0[5:3], 11'h004, 16'h91AA, r[23:0], 24'hFFFFFF});
        @(posedge pclk);
        frame_in.sof <= 1'b1;
        frame_in.frame_len <= len;
        frame_in.dst_addr <= dst;
        frame_in.vid_check <= 1'b1;
        frame_in.vid_invalid <= inv;
        frame_in.vid_unknown <= unk;
        frame_in.data_valid <= 1'b1;
        frame_in.sa_check <= 1'b1;
        frame_in.entry_update <= 1'b1;
        frame_in.src_addr <= {r[23:0], 23'h7FFFFF, lk0[0]};
        @(posedge pclk);
        frame_in.sof <= 1'b0;
        frame_in.vid_check <= 1'b0;
        frame_in.sa_check <= 1'b0;
        frame_in.entry_update <= 1'b0;
        @(posedge pclk);
        frame_in.data_valid <= 1'b0;
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Checking
    // ----------------------------------------------------------------
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0
            && rq.size() > 0) begin
            rexp = rq.pop_front();
            checks_done++;
            if ({pslverr, prdata} !== rexp) begin
                error_cnt++;
                $display("ERROR read %h expected %h seen %h", paddr, rexp, {pslverr, prdata});
            end
        end
        if (sof_prev === 1'b1 && fq.size() > 0) begin
            fexp = fq.pop_front();
            checks_done++;
            if (fseen !== fexp) begin
                error_cnt++;
                $display("ERROR frame expected %h seen %h", fexp, fseen);
            end
        end
        sof_prev = frame_in.sof;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, sof_prev, ufwd} = 5'h0;
        paddr = '0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        frame_in = '0;
        station_addr_hi = 24'h0;
        lfsr = 32'h510F;
        lk0 = 8'h61;
        acct = 2'h3;
        error_cnt = 0;
        checks_done = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 10; i++)
                apb(1'b0, ri[i], 32'h0, 4'h0, {17'h0, rv[i]});
            if (p == 0) begin
                for (int i = 0; i < 7; i++) begin
                    r = rnd();
                    apb(1'b1, ri[i], r, 4'hF, 33'h0);
                    apb(1'b0, ri[i], 32'h0, 4'h0, {1'b0, r & {16'h0, rm[i]}});
                end
                apb(1'b1, 10'h308, 32'h2328, 4'hF, 33'h0);
                apb(1'b0, 10'h308, 32'h0, 4'h0, {17'h0, JUMBO_PAYLOAD});
                apb(1'b0, 10'h301, 32'h0, 4'h0, {1'b1, 32'h0});
                apb(1'b1, 10'h300, 32'h2, 4'hF, 33'h0);
            end
        end
        apb(1'b1, 10'h30A, 32'h55AA, 4'h1, 33'h0);
        apb(1'b0, 10'h30A, 32'h0, 4'h0, {17'h0, 16'h91AA});
        for (int i = 0; i < 8; i++) begin
            lk0 = {(i != 3), i[0], 3'h4, i[2], i[1:0]};
            acct = i[2:1];
            ufwd = i[2];
            apb(1'b1, 10'h310, {24'h0, lk0}, 4'hF, 33'h0);
            apb(1'b1, 10'h30E, {30'h0, acct}, 4'hF, 33'h0);
            apb(1'b1, 10'h314, {31'h0, ufwd}, 4'hF, 33'h0);
            apb(1'b1, 10'h300, {24'h0, ufwd, 7'h00}, 4'hF, 33'h0);
            apb(1'b1, 10'h308, {31'h0, i[0]}, 4'hF, 33'h0);
            r = rnd();
            station_addr_hi <= r[23:0];
            frm({r[15:0], rnd()}, r[31:16] & 16'h3FFF, (i != 5), i[1]);
        end
        repeat (2) @(posedge pclk);
        print_verdict();
    end
endmodule // lookup_cfg_bank_tb
`default_nettype wire
